// File: rtl/lie_cfg.svh
// constants for the lcd instruction executor and its host controller
// assumes both ends run on one clock, pclk at 100 MHz
`ifndef LIE_CFG_SVH
`define LIE_CFG_SVH

// host register offsets (apb byte addresses)
`define LIE_OFF_CTRL     8'h00
`define LIE_OFF_CMD      8'h04
`define LIE_OFF_STAT     8'h08
// ctrl fields
`define LIE_CTRL_NIBBLE  0
`define LIE_CTRL_PD      1
`define LIE_CTRL_SERIAL  2
`define LIE_CTRL_TIMED   3
`define LIE_CTRL_W       4
// cmd fields
`define LIE_CMD_RS       8
`define LIE_CMD_RD       9
// status fields
`define LIE_STAT_BUSY    0
`define LIE_STAT_RDATA   8

// instruction codes and ram map
`define LIE_CODE_CLEAR   8'h01
`define LIE_CODE_BLANK   8'h20
`define LIE_LINE1_LAST   7'h27
`define LIE_LINE2_FIRST  7'h40
`define LIE_LINE2_LAST   7'h67
`define LIE_ONE_LAST     7'h4f

// timing in oscillator cycles; one oscillator cycle is OSC_DIV pclk cycles
`define LIE_OSC_DIV      1
`define LIE_CLEAR_OSC    165
`define LIE_EXEC_OSC     2
`define LIE_SETTLE_OSC   3
`define LIE_BLINK_DIV    52224
// host strobe shape in pclk cycles
`define LIE_E_HIGH       8'd4
`define LIE_E_LOW        8'd4

// display format
`define LIE_CURSOR_ROW   4'h8
`define LIE_CHARS_ONE    6'h20
`define LIE_CHARS_TWO    6'h10
`define LIE_ROWS_MUX9    18'h100ff
`define LIE_ROWS_ALL     18'h3ffff

`endif

// File: rtl/lie_device.sv
// lcd instruction executor: basic instruction set, address counter,
// data latch, display and glyph ram, display control state
// assumes the host drives the link on pclk; strobe falls end a transfer
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "lie_cfg.svh"
module lie_device #(
	parameter int BLINK_PERIOD = `LIE_BLINK_DIV
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// link to host
	lie_if.device            link,
	// display state
	output logic             display_on,
	output logic             cursor_underline,
	output logic             cursor_block,
	output logic [3:0]       cursor_row,
	output logic             lcd_blank,
	output logic             gen_enable,
	output logic             osc_stop_ok,
	output logic [6:0]       display_offset,
	output logic [6:0]       address_counter,
	output logic             busy_flag,
	// format state
	output logic             interface_8bit,
	output logic             two_line_select,
	output logic             mux9_select,
	output logic             extended_set_select,
	output logic [5:0]       chars_per_line,
	output logic [17:0]      row_enable,
	// display ram view
	input  wire logic [6:0]  view_addr,
	output logic [7:0]       view_char
);
	localparam logic [15:0] BLINK_HALF = 16'(BLINK_PERIOD / 2 - 1);
	localparam logic [7:0]  CLEAR_CYC = 8'(`LIE_CLEAR_OSC * `LIE_OSC_DIV);
	localparam logic [7:0]  EXEC_CYC = 8'(`LIE_EXEC_OSC * `LIE_OSC_DIV);
	localparam logic [3:0]  SETTLE_CYC = 4'(`LIE_SETTLE_OSC * `LIE_OSC_DIV);

	logic [7:0]      disp_ram [128];
	logic [4:0]      glyph_ram [64];
	logic            strobe_q;
	logic            nib_phase;
	logic [3:0]      hi_nib;
	logic            increment_direction;
	logic            shift_on_write;
	logic            cursor_on;
	logic            cursor_blink;
	logic            glyph_sel;
	logic [7:0]      data_latch;
	logic            reload;
	logic [7:0]      busy_cnt;
	logic [7:0]      next_busy_cnt;
	logic [15:0]     blink_cnt;
	logic            blink_phase;
	logic [3:0]      settle_cnt;
	logic            strobe_fall;
	logic            byte_done;
	logic [7:0]      cur_byte;
	logic            do_instr;
	logic            do_wr;
	logic            do_rd;
	logic            wrap2;
	logic [7:0]      rd_byte;
	logic [7:0]      out_byte;
	lie_pkg::lie_op_t op;

	// step across the display map, or flat inside glyph ram
	function automatic logic [6:0] lie_step(input logic [6:0] a,
			input logic up, input logic two, input logic flat);
		logic [6:0] r;
		r = up ? a + 7'h01 : a - 7'h01;
		if (!flat && two) begin
			if (up && a == `LIE_LINE1_LAST)
				r = `LIE_LINE2_FIRST;
			else if (up && a == `LIE_LINE2_LAST)
				r = 7'h00;
			else if (!up && a == 7'h00)
				r = `LIE_LINE2_LAST;
			else if (!up && a == `LIE_LINE2_FIRST)
				r = `LIE_LINE1_LAST;
		end else if (!flat) begin
			if (up && a == `LIE_ONE_LAST)
				r = 7'h00;
			else if (!up && a == 7'h00)
				r = `LIE_ONE_LAST;
		end
		return r;
	endfunction

	assign strobe_fall = strobe_q & ~link.enable_strobe;
	assign byte_done = strobe_fall & (interface_8bit | nib_phase);
	assign cur_byte = interface_8bit ? link.bus_level
		: {hi_nib, link.bus_level[7:4]};
	// busy holds off everything but the status read
	assign do_instr = byte_done & ~link.register_select
		& ~link.read_not_write & ~busy_flag;
	assign do_wr = byte_done & link.register_select
		& ~link.read_not_write & ~busy_flag;
	assign do_rd = byte_done & link.register_select
		& link.read_not_write & ~busy_flag;
	assign wrap2 = two_line_select | mux9_select;
	assign rd_byte = glyph_sel ? {3'h0, glyph_ram[address_counter[5:0]]}
		: disp_ram[address_counter];
	assign out_byte = link.register_select ? data_latch
		: {busy_flag, address_counter};

	always_comb begin
		op = lie_pkg::LIE_OP_NONE;
		if (extended_set_select) begin
			if (cur_byte[7:5] == 3'h1)
				op = lie_pkg::LIE_OP_FUNC;
		end else begin
			casez (cur_byte)
				8'b1???????: op = lie_pkg::LIE_OP_DDA;
				8'b01??????: op = lie_pkg::LIE_OP_CGA;
				8'b001?????: op = lie_pkg::LIE_OP_FUNC;
				8'b0001????: op = lie_pkg::LIE_OP_SHIFT;
				8'b00001???: op = lie_pkg::LIE_OP_DISP;
				8'b000001??: op = lie_pkg::LIE_OP_ENTRY;
				8'b0000001?: op = lie_pkg::LIE_OP_HOME;
				8'b00000001: op = lie_pkg::LIE_OP_CLEAR;
				default:     op = lie_pkg::LIE_OP_NONE;
			endcase
		end
	end

	// link front: strobe edge and nibble pairing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strobe_q <= 1'b0;
			nib_phase <= 1'b0;
			hi_nib <= 4'h0;
		end else begin
			strobe_q <= link.enable_strobe;
			if (interface_8bit)
				nib_phase <= 1'b0;
			else if (strobe_fall) begin
				nib_phase <= ~nib_phase;
				if (!nib_phase)
					hi_nib <= link.bus_level[7:4];
			end
		end
	end

	// read answer: whole byte, or high then low nibble on lines 7..4
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link.dev_data <= 8'h00;
			link.dev_data_oe_n <= 8'hff;
		end else if (link.enable_strobe && link.read_not_write) begin
			if (interface_8bit) begin
				link.dev_data <= out_byte;
				link.dev_data_oe_n <= 8'h00;
			end else begin
				link.dev_data <= nib_phase ? {out_byte[3:0], 4'h0}
					: {out_byte[7:4], 4'h0};
				link.dev_data_oe_n <= 8'h0f;
			end
		end else begin
			link.dev_data <= 8'h00;
			link.dev_data_oe_n <= 8'hff;
		end
	end

	// mode registers; display off does not stop decoding
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			increment_direction <= 1'b1;
			shift_on_write <= 1'b0;
			display_on <= 1'b0;
			cursor_on <= 1'b0;
			cursor_blink <= 1'b0;
			interface_8bit <= 1'b1;
			two_line_select <= 1'b0;
			mux9_select <= 1'b0;
			extended_set_select <= 1'b0;
		end else if (do_instr) begin
			case (op)
				lie_pkg::LIE_OP_CLEAR: increment_direction <= 1'b1;
				lie_pkg::LIE_OP_ENTRY: begin
					increment_direction <= cur_byte[1];
					shift_on_write <= cur_byte[0];
				end
				lie_pkg::LIE_OP_DISP: begin
					display_on <= cur_byte[2];
					cursor_on <= cur_byte[1];
					cursor_blink <= cur_byte[0];
				end
				lie_pkg::LIE_OP_FUNC: begin
					interface_8bit <= link.serial_sel | cur_byte[4];
					two_line_select <= cur_byte[2];
					mux9_select <= cur_byte[1];
					extended_set_select <= cur_byte[0];
				end
				default: ;
			endcase
		end
	end

	// address counter, ram target and display offset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			address_counter <= 7'h00;
			glyph_sel <= 1'b0;
			display_offset <= 7'h00;
		end else if (do_instr) begin
			case (op)
				lie_pkg::LIE_OP_CLEAR, lie_pkg::LIE_OP_HOME: begin
					address_counter <= 7'h00;
					display_offset <= 7'h00;
					if (op == lie_pkg::LIE_OP_CLEAR)
						glyph_sel <= 1'b0;
				end
				lie_pkg::LIE_OP_SHIFT: begin
					if (!cur_byte[3])
						address_counter <= lie_step(address_counter,
							cur_byte[2], wrap2, 1'b0);
					else if (cur_byte[2])
						display_offset <= display_offset - 7'h01;
					else
						display_offset <= display_offset + 7'h01;
				end
				lie_pkg::LIE_OP_CGA: begin
					address_counter <= {address_counter[6],
						cur_byte[5:0]};
					glyph_sel <= 1'b1;
				end
				lie_pkg::LIE_OP_DDA: begin
					address_counter <= cur_byte[6:0];
					glyph_sel <= 1'b0;
				end
				default: ;
			endcase
		end else if (do_wr || do_rd) begin
			address_counter <= lie_step(address_counter,
				increment_direction, wrap2, glyph_sel);
			if (do_wr && shift_on_write && !glyph_sel)
				display_offset <= increment_direction
					? display_offset + 7'h01
					: display_offset - 7'h01;
		end
	end

	// ram storage; reset leaves the display blank
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 128; i++)
				disp_ram[i] <= `LIE_CODE_BLANK;
			for (int i = 0; i < 64; i++)
				glyph_ram[i] <= 5'h00;
		end else if (do_instr && op == lie_pkg::LIE_OP_CLEAR) begin
			for (int i = 0; i < 128; i++)
				disp_ram[i] <= `LIE_CODE_BLANK;
		end else if (do_wr && glyph_sel) begin
			glyph_ram[address_counter[5:0]] <= cur_byte[4:0];
		end else if (do_wr) begin
			disp_ram[address_counter] <= cur_byte;
		end
	end

	// latch reload one cycle later, at the counter's new value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reload <= 1'b0;
			data_latch <= 8'h00;
		end else begin
			reload <= do_rd | (do_instr & (op == lie_pkg::LIE_OP_CGA
				| op == lie_pkg::LIE_OP_DDA));
			if (reload)
				data_latch <= rd_byte;
		end
	end

	always_comb begin
		next_busy_cnt = busy_cnt;
		if (do_instr)
			next_busy_cnt = (op == lie_pkg::LIE_OP_CLEAR)
				? CLEAR_CYC : EXEC_CYC;
		else if (do_wr || do_rd)
			next_busy_cnt = EXEC_CYC;
		else if (busy_cnt != 8'h00)
			next_busy_cnt = busy_cnt - 8'h01;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_cnt <= 8'h00;
			busy_flag <= 1'b0;
		end else begin
			busy_cnt <= next_busy_cnt;
			busy_flag <= next_busy_cnt != 8'h00;
		end
	end

	// blink divider; free running so phase is steady across commands
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blink_cnt <= 16'h0000;
			blink_phase <= 1'b1;
		end else if (blink_cnt == BLINK_HALF) begin
			blink_cnt <= 16'h0000;
			blink_phase <= ~blink_phase;
		end else begin
			blink_cnt <= blink_cnt + 16'h0001;
		end
	end

	// outputs settle to ground before the oscillator may stop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_cnt <= SETTLE_CYC;
			osc_stop_ok <= 1'b0;
		end else begin
			if (display_on)
				settle_cnt <= SETTLE_CYC;
			else if (settle_cnt != 4'h0)
				settle_cnt <= settle_cnt - 4'h1;
			osc_stop_ok <= !display_on && settle_cnt == 4'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cursor_underline <= 1'b0;
			cursor_block <= 1'b0;
			cursor_row <= `LIE_CURSOR_ROW;
			lcd_blank <= 1'b1;
			gen_enable <= 1'b0;
			chars_per_line <= `LIE_CHARS_ONE;
			row_enable <= `LIE_ROWS_ALL;
			view_char <= 8'h00;
		end else begin
			cursor_underline <= display_on & cursor_on & ~glyph_sel
				& (blink_phase | ~cursor_blink);
			cursor_block <= display_on & cursor_blink & ~glyph_sel
				& blink_phase;
			cursor_row <= `LIE_CURSOR_ROW;
			lcd_blank <= ~display_on | link.power_down_pin;
			gen_enable <= display_on & ~link.power_down_pin;
			chars_per_line <= (two_line_select | mux9_select)
				? `LIE_CHARS_TWO : `LIE_CHARS_ONE;
			row_enable <= mux9_select ? `LIE_ROWS_MUX9
				: `LIE_ROWS_ALL;
			view_char <= disp_ram[view_addr];
		end
	end
endmodule // lie_device
`default_nettype wire

// File: rtl/lie_host.sv
// host controller: software queues one byte transfer over apb,
// this end runs the strobe, nibble split and busy handling
// assumes the device samples on the strobe fall and answers while high
`timescale 1ns/1ps
`default_nettype none
`include "lie_cfg.svh"
module lie_host (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// link to device
	lie_if.host              link
);
	localparam logic [7:0] CLEAR_WAIT = 8'(`LIE_CLEAR_OSC * `LIE_OSC_DIV);

	logic [3:0]  ctrl;
	logic [7:0]  cmd_byte;
	logic        cmd_rs;
	logic        cmd_rd;
	logic [7:0]  rdata;
	logic [7:0]  rx;
	logic [7:0]  cnt;
	logic        nib;
	logic        polling;
	logic        cur_rs;
	logic        cur_rd;
	logic [7:0]  cur_byte;
	logic        wr_acc;
	logic        mapped;
	lie_pkg::lie_hstate_t state;

	assign wr_acc = psel & penable & pready & pwrite;
	assign mapped = paddr == `LIE_OFF_CTRL || paddr == `LIE_OFF_CMD
		|| paddr == `LIE_OFF_STAT;
	// a poll is a status read ahead of the queued transfer
	assign cur_rs = polling ? 1'b0 : cmd_rs;
	assign cur_rd = polling ? 1'b1 : cmd_rd;
	assign cur_byte = cmd_byte;

	// zero wait apb: answer prepared in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			prdata <= 32'h0000_0000;
			if (psel && !penable && paddr == `LIE_OFF_CTRL)
				prdata <= {28'h0000000, ctrl};
			else if (psel && !penable && paddr == `LIE_OFF_STAT)
				prdata <= {16'h0000, rdata, 7'h00,
					state != lie_pkg::LIE_H_IDLE};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl <= 4'h0;
		else if (wr_acc && paddr == `LIE_OFF_CTRL)
			ctrl <= pwdata[`LIE_CTRL_W-1:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link.power_down_pin <= 1'b0;
			link.serial_sel <= 1'b0;
		end else begin
			link.power_down_pin <= ctrl[`LIE_CTRL_PD];
			link.serial_sel <= ctrl[`LIE_CTRL_SERIAL];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= lie_pkg::LIE_H_IDLE;
			cmd_byte <= 8'h00;
			cmd_rs <= 1'b0;
			cmd_rd <= 1'b0;
			polling <= 1'b0;
			nib <= 1'b0;
			cnt <= 8'h00;
			rx <= 8'h00;
			rdata <= 8'h00;
			link.enable_strobe <= 1'b0;
			link.register_select <= 1'b0;
			link.read_not_write <= 1'b0;
			link.host_data <= 8'h00;
			link.host_data_oe_n <= 8'hff;
		end else begin
			case (state)
				lie_pkg::LIE_H_IDLE: begin
					if (wr_acc && paddr == `LIE_OFF_CMD) begin
						cmd_byte <= pwdata[7:0];
						cmd_rs <= pwdata[`LIE_CMD_RS];
						cmd_rd <= pwdata[`LIE_CMD_RD];
						polling <= ~ctrl[`LIE_CTRL_TIMED];
						nib <= 1'b0;
						state <= lie_pkg::LIE_H_SETUP;
					end
				end
				lie_pkg::LIE_H_SETUP: begin
					link.register_select <= cur_rs;
					link.read_not_write <= cur_rd;
					if (!ctrl[`LIE_CTRL_NIBBLE]) begin
						link.host_data <= cur_byte;
						link.host_data_oe_n <= cur_rd ? 8'hff : 8'h00;
					end else begin
						// lower lines float high, relies on it
						link.host_data <= nib ? {cur_byte[3:0], 4'h0}
							: {cur_byte[7:4], 4'h0};
						link.host_data_oe_n <= cur_rd ? 8'hff : 8'h0f;
					end
					link.enable_strobe <= 1'b1;
					cnt <= `LIE_E_HIGH;
					state <= lie_pkg::LIE_H_HIGH;
				end
				lie_pkg::LIE_H_HIGH: begin
					cnt <= cnt - 8'h01;
					if (cnt == 8'h01) begin
						if (!ctrl[`LIE_CTRL_NIBBLE])
							rx <= link.bus_level;
						else if (!nib)
							rx[7:4] <= link.bus_level[7:4];
						else
							rx[3:0] <= link.bus_level[7:4];
						link.enable_strobe <= 1'b0;
						cnt <= `LIE_E_LOW;
						state <= lie_pkg::LIE_H_LOW;
					end
				end
				lie_pkg::LIE_H_LOW: begin
					cnt <= cnt - 8'h01;
					link.host_data_oe_n <= 8'hff;
					if (cnt != 8'h01) begin
						state <= lie_pkg::LIE_H_LOW;
					end else if (ctrl[`LIE_CTRL_NIBBLE] && !nib) begin
						nib <= 1'b1;
						state <= lie_pkg::LIE_H_SETUP;
					end else if (polling) begin
						nib <= 1'b0;
						polling <= rx[7];
						state <= lie_pkg::LIE_H_SETUP;
					end else begin
						nib <= 1'b0;
						if (cmd_rd)
							rdata <= rx;
						if (ctrl[`LIE_CTRL_TIMED] && !cmd_rs && !cmd_rd
								&& cmd_byte == `LIE_CODE_CLEAR) begin
							cnt <= CLEAR_WAIT;
							state <= lie_pkg::LIE_H_WAIT;
						end else begin
							state <= lie_pkg::LIE_H_IDLE;
						end
					end
				end
				lie_pkg::LIE_H_WAIT: begin
					cnt <= cnt - 8'h01;
					if (cnt == 8'h01)
						state <= lie_pkg::LIE_H_IDLE;
				end
				default: state <= lie_pkg::LIE_H_IDLE;
			endcase
		end
	end
endmodule // lie_host
`default_nettype wire

// File: rtl/lie_if.sv
// parallel lcd bus between host controller and instruction executor
// assumes both ends share pclk; undriven data lines read high (pull-ups)
`timescale 1ns/1ps
`default_nettype none
interface lie_if;
	logic       enable_strobe;
	logic       register_select;
	logic       read_not_write;
	logic       power_down_pin;
	logic       serial_sel;
	logic [7:0] host_data;
	logic [7:0] host_data_oe_n;
	logic [7:0] dev_data;
	logic [7:0] dev_data_oe_n;
	logic [7:0] bus_level;

	// per line: device, else host, else pull-up
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!dev_data_oe_n[i])
				bus_level[i] = dev_data[i];
			else if (!host_data_oe_n[i])
				bus_level[i] = host_data[i];
			else
				bus_level[i] = 1'b1;
		end
	end

	modport device (
		input  enable_strobe, register_select, read_not_write,
		input  power_down_pin, serial_sel, bus_level,
		output dev_data, dev_data_oe_n
	);
	modport host (
		output enable_strobe, register_select, read_not_write,
		output power_down_pin, serial_sel, host_data, host_data_oe_n,
		input  bus_level
	);
endinterface
`default_nettype wire

// File: rtl/lie_pkg.sv
// types shared by the lcd instruction executor ends
// assumes lie_cfg.svh holds the numeric constants
package lie_pkg;
	typedef enum logic [3:0] {
		LIE_OP_NONE, LIE_OP_CLEAR, LIE_OP_HOME, LIE_OP_ENTRY, LIE_OP_DISP,
		LIE_OP_SHIFT, LIE_OP_FUNC, LIE_OP_CGA, LIE_OP_DDA
	} lie_op_t;
	typedef enum logic [2:0] {
		LIE_H_IDLE, LIE_H_SETUP, LIE_H_HIGH, LIE_H_LOW, LIE_H_WAIT
	} lie_hstate_t;
endpackage

// File: verif/lie_link_asserts.sv
// checker for the link between host controller and executor
// assumes the bench wires it to the lie_if signals beside the interface
`timescale 1ns/1ps
`default_nettype none
module lie_link_asserts (
	// clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// link
	input wire logic       enable_strobe,
	input wire logic       register_select,
	input wire logic       read_not_write,
	input wire logic [7:0] host_data_oe_n,
	input wire logic [7:0] dev_data_oe_n,
	input wire logic [7:0] bus_level
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_strobe_high_four: assert property (
		$rose(enable_strobe) |-> enable_strobe[*4] ##1 !enable_strobe)
		else $error("strobe high phase wrong");
	a_strobe_low_four: assert property (
		$fell(enable_strobe) |-> !enable_strobe[*4])
		else $error("strobe low phase wrong");
	a_ctrl_steady: assert property (
		enable_strobe && !$rose(enable_strobe)
		|-> $stable(register_select) && $stable(read_not_write))
		else $error("control moved during strobe");
	a_ctrl_held_low: assert property (
		$fell(enable_strobe) |-> $stable(register_select)[*4])
		else $error("select moved in low phase");
	a_read_host_off: assert property (
		enable_strobe && read_not_write |-> host_data_oe_n == 8'hff)
		else $error("host drives during read");
	a_write_dev_off: assert property (
		enable_strobe && !read_not_write |-> dev_data_oe_n == 8'hff)
		else $error("device drives during write");
	a_read_dev_on: assert property (
		enable_strobe && $past(enable_strobe) && read_not_write
		|-> dev_data_oe_n != 8'hff)
		else $error("device silent during read");
	a_dev_release: assert property (
		$fell(enable_strobe) |-> ##[0:2] dev_data_oe_n == 8'hff)
		else $error("device keeps bus after strobe");
	a_open_pull_up: assert property (
		(host_data_oe_n[3:0] & dev_data_oe_n[3:0]) == 4'hf
		|-> bus_level[3:0] == 4'hf)
		else $error("released lines not high");

	c_read: cover property ($fell(enable_strobe) && read_not_write);
	c_data: cover property ($fell(enable_strobe) && register_select);
	c_nibble: cover property (enable_strobe && host_data_oe_n == 8'h0f);
endmodule // lie_link_asserts
`default_nettype wire

// File: verif/tb_lcd_instruction_executor.sv
// bench: host and executor joined by lie_if, driven over apb
// assumes lie_cfg.svh is on the include path
`timescale 1ns/1ps
`default_nettype none
`include "lie_cfg.svh"
module tb_lcd_instruction_executor;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, view_char;
	logic [31:0] pwdata, prdata, rd, blen;
	logic        err, display_on, cursor_underline, cursor_block;
	logic        bsave;
	logic        lcd_blank, gen_enable, osc_stop_ok, busy_flag;
	logic        interface_8bit, two_line_select, mux9_select;
	logic        extended_set_select;
	logic [3:0]  cursor_row;
	logic [6:0]  display_offset, address_counter, view_addr;
	logic [5:0]  chars_per_line;
	logic [17:0] row_enable;
	int          num_errors, checked, bcnt;

	lie_if link();
	lie_host lie_host_inst (.pclk, .presetn, .paddr, .psel, .penable,
		.pwrite, .pwdata, .prdata, .pready, .pslverr, .link);
	// short blink period keeps the run brief
	lie_device #(.BLINK_PERIOD(16)) lie_device_inst (.pclk, .presetn,
		.link, .display_on, .cursor_underline, .cursor_block, .cursor_row,
		.lcd_blank, .gen_enable, .osc_stop_ok, .display_offset,
		.address_counter, .busy_flag, .interface_8bit, .two_line_select,
		.mux9_select, .extended_set_select, .chars_per_line, .row_enable,
		.view_addr, .view_char);
	lie_link_asserts lie_link_asserts_inst (.pclk, .presetn,
		.enable_strobe(link.enable_strobe),
		.register_select(link.register_select),
		.read_not_write(link.read_not_write),
		.host_data_oe_n(link.host_data_oe_n),
		.dev_data_oe_n(link.dev_data_oe_n),
		.bus_level(link.bus_level));

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			num_errors++;
			$display("wrong value at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// pready is registered, so its level before the edge is the sample
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic cmd(input logic [9:0] c);
		apb(`LIE_OFF_CMD, 1'b1, {22'h0, c});
		rd = 32'h1;
		while (rd[`LIE_STAT_BUSY] !== 1'b0)
			apb(`LIE_OFF_STAT, 1'b0, 32'h0);
		do @(negedge pclk); while (busy_flag !== 1'b0);
		@(posedge pclk);
	endtask
	task automatic ram(input logic [6:0] a, input logic [7:0] e);
		view_addr <= a;
		repeat (3) @(posedge pclk);
		chk(32'(view_char), 32'(e));
	endtask
	task automatic ac(input logic [6:0] e);
		chk(32'(address_counter), 32'(e));
	endtask

	task automatic t_reset;
		chk(32'({display_on, lcd_blank, gen_enable}), 32'h2);
		chk(32'({interface_8bit, chars_per_line}), 32'h60);
		apb(8'h0c, 1'b0, 32'h0);
		chk({rd[30:0], err}, 32'h1);
	endtask
	task automatic t_write;
		cmd(10'h00f);
		chk(32'({display_on, lcd_blank, gen_enable}), 32'h5);
		chk(32'(cursor_row), 32'h8);
		chk(32'(cursor_underline), 32'(cursor_block));
		bsave = cursor_block;
		repeat (8) @(posedge pclk);
		chk(32'(cursor_block), 32'(!bsave));
		cmd(10'h085);
		ac(7'h05);
		cmd(10'h141);
		cmd(10'h142);
		ac(7'h07);
		ram(7'h05, 8'h41);
		ram(7'h06, 8'h42);
	endtask
	task automatic t_shift;
		cmd(10'h007);
		cmd(10'h143);
		chk(32'(display_offset), 32'h1);
		cmd(10'h006);
		cmd(10'h018);
		chk(32'({display_offset, address_counter}), 32'h108);
		cmd(10'h014);
		chk(32'({display_offset, address_counter}), 32'h109);
		cmd(10'h002);
		chk(32'({display_offset, address_counter}), 32'h0);
		ram(7'h05, 8'h41);
	endtask
	task automatic t_read;
		cmd(10'h085);
		cmd(10'h300);
		chk(32'({rd[15:8], 1'b0, address_counter}), 32'h4106);
		cmd(10'h300);
		chk(32'({rd[15:8], 1'b0, address_counter}), 32'h4207);
		cmd(10'h155);
		cmd(10'h300);
		chk(32'({rd[15:8], 1'b0, address_counter}), 32'h4309);
		ram(7'h07, 8'h55);
		cmd(10'h200);
		chk(32'(rd[15:8]), 32'h09);
	endtask
	task automatic t_glyph;
		cmd(10'h0c5);
		cmd(10'h043);
		ac(7'h43);
		chk(32'({cursor_underline, cursor_block}), 32'h0);
		repeat (8) @(posedge pclk);
		chk(32'({cursor_underline, cursor_block}), 32'h0);
		cmd(10'h1ff);
		chk(32'({display_offset, address_counter}), 32'h44);
		cmd(10'h043);
		cmd(10'h300);
		chk(32'(rd[15:8]), 32'h1f);
	endtask
	task automatic t_off;
		cmd(10'h008);
		chk(32'({display_on, lcd_blank, gen_enable}), 32'h2);
		chk(32'(osc_stop_ok), 32'h1);
		cmd(10'h080);
		ac(7'h00);
		apb(`LIE_OFF_CTRL, 1'b1, 32'h2);
		cmd(10'h00c);
		chk(32'({display_on, lcd_blank, gen_enable}), 32'h6);
		apb(`LIE_OFF_CTRL, 1'b1, 32'h0);
		cmd(10'h00c);
		chk(32'({display_on, lcd_blank, gen_enable}), 32'h5);
	endtask
	task automatic t_clear;
		cmd(10'h004);
		cmd(10'h01c);
		apb(`LIE_OFF_CTRL, 1'b1, 32'h8);
		cmd(10'h001);
		@(posedge pclk);
		chk(32'(blen >= 165 && blen <= 167), 32'h1);
		chk(32'({display_offset, address_counter}), 32'h0);
		ram(7'h05, 8'h20);
		cmd(10'h161);
		ac(7'h01);
		apb(`LIE_OFF_CTRL, 1'b1, 32'h0);
	endtask
	task automatic t_format;
		cmd(10'h020);
		chk(32'(interface_8bit), 32'h0);
		apb(`LIE_OFF_CTRL, 1'b1, 32'h1);
		cmd(10'h024);
		chk(32'({two_line_select, chars_per_line}), 32'h50);
		cmd(10'h0a7);
		cmd(10'h014);
		ac(7'h40);
		cmd(10'h026);
		chk(32'({mux9_select, row_enable}), 32'h500ff);
		cmd(10'h025);
		cmd(10'h080);
		chk(32'({extended_set_select, address_counter}), 32'hc0);
		cmd(10'h030);
		chk(32'({interface_8bit, extended_set_select}), 32'h2);
		apb(`LIE_OFF_CTRL, 1'b1, 32'h4);
		cmd(10'h020);
		chk(32'(interface_8bit), 32'h1);
		apb(`LIE_OFF_CTRL, 1'b1, 32'h0);
	endtask

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// length of the last busy stretch
	always @(posedge pclk) begin
		if (busy_flag === 1'b1)
			bcnt <= bcnt + 1;
		else if (bcnt != 0) begin
			blen <= bcnt;
			bcnt <= 0;
		end
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		view_addr = 7'h00;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset;
		t_write;
		t_shift;
		t_read;
		t_glyph;
		t_off;
		t_clear;
		t_format;
		wrap_up;
	end
	initial begin
		repeat (30000) @(posedge pclk);
		num_errors++;
		wrap_up;
	end
endmodule // tb_lcd_instruction_executor
`default_nettype wire
